// [bench/acfg_host_model.sv]
/*
  Host of the serial command link: frames bytes MSB first.
  Assumes sclk of 320 ns, idle low, and 25 MHz master clock.
*/
module acfg_host_model (
  // Serial pins
  output logic      sclk,
  output logic      din,
  output logic      cs_n,
  input  wire logic dout
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       listen;
  logic [7:0] rx_last;
  event       got;

  initial begin
    sclk = 1'b0;
    din = 1'b1;
    cs_n = 1'b1;
    listen = 1'b0;
  end
  task automatic frame_begin();
    #13 cs_n = 1'b0;
    #200;
  endtask : frame_begin
  task automatic frame_end();
    #200 cs_n = 1'b1;
    din = ~din;
    #400;
  endtask : frame_end
  task automatic xfer(input logic [7:0] tx);
    for (int i = 7; i >= 0; i--) begin
      din = tx[i];
      #160 rx_last[i] = dout;
      sclk = 1'b1;
      #160 sclk = 1'b0;
    end
    // Released line shows no stale value
    din = ~din;
    if (listen) ->got;
    #1200;
  endtask : xfer
endmodule : acfg_host_model

// [bench/acfg_port_assertions.sv]
/*
  Port checker of acfg_port, bound to every instance.
  Assumes one clock domain, core_clk, with reset_n active low.
*/
module acfg_port_chk (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        clk_en,
  // Link and control
  input wire logic        sclk,
  input wire logic        cs_n,
  input wire logic        dout,
  input wire logic        offset_cal_start,
  input wire logic        gain_cal_start,
  input wire logic        offset_cal_done,
  input wire logic        gain_cal_done,
  input wire logic [23:0] cal_result,
  input wire logic        conversion_restart,
  // Words
  input wire logic [15:0] highpass_corner,
  input wire logic [23:0] offset_correction,
  input wire logic [23:0] gain_correction
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************
  // Properties
  // ************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  property p_restart_pulse; conversion_restart |=> !conversion_restart; endproperty
  a_restart_pulse: assert property (p_restart_pulse) else $error("restart too long");
  property p_ofs_start; offset_cal_start |=> !offset_cal_start; endproperty
  a_ofs_start: assert property (p_ofs_start) else $error("offset start too long");
  property p_gain_start; gain_cal_start |=> !gain_cal_start; endproperty
  a_gain_start: assert property (p_gain_start) else $error("gain start too long");
  property p_ofs_done;
    offset_cal_done && clk_en |=> offset_correction == $past(cal_result);
  endproperty
  a_ofs_done: assert property (p_ofs_done) else $error("offset result lost");
  property p_gain_done;
    gain_cal_done && clk_en |=> gain_correction == $past(cal_result);
  endproperty
  a_gain_done: assert property (p_gain_done) else $error("gain result lost");
  property p_dout_idle; cs_n [*5] |-> !dout; endproperty
  a_dout_idle: assert property (p_dout_idle) else $error("dout driven unselected");
  property p_dout_edge; $changed(dout) |-> !sclk; endproperty
  a_dout_edge: assert property (p_dout_edge) else $error("dout moved, sclk high");
  property p_hpf_cause; $changed(highpass_corner) |-> conversion_restart; endproperty
  a_hpf_cause: assert property (p_hpf_cause) else $error("corner changed unwritten");
  property p_ofs_cause;
    $changed(offset_correction) |-> conversion_restart || $past(offset_cal_done);
  endproperty
  a_ofs_cause: assert property (p_ofs_cause) else $error("offset changed uncaused");
  c_restart: cover property (conversion_restart);
  c_ofs: cover property (offset_cal_start);
  c_gain: cover property (gain_cal_start);
endmodule : acfg_port_chk

bind acfg_port acfg_port_chk chk (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
  .sclk(sclk), .cs_n(cs_n), .dout(dout), .offset_cal_start(offset_cal_start),
  .gain_cal_start(gain_cal_start), .offset_cal_done(offset_cal_done),
  .gain_cal_done(gain_cal_done), .cal_result(cal_result),
  .conversion_restart(conversion_restart), .highpass_corner(highpass_corner),
  .offset_correction(offset_correction), .gain_correction(gain_correction));

// [bench/adc_config_register_port_tb.sv]
/*
  Self-checking bench of acfg_port: reads, writes, aborts, calibration.
  Assumes the host model drives the serial pins.
*/
module adc_config_register_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, reset_n, clk_en, offset_cal_done, gain_cal_done;
  logic [23:0] cal_result, offset_correction, gain_correction;
  logic        sclk, din, cs_n, dout, offset_cal_start, gain_cal_start;
  logic        conversion_restart, sync_continuous, high_resolution;
  logic        min_phase, chopping_enable;
  logic [1:0]  offset_option, filter_chain;
  logic [2:0]  output_rate, input_selector, gain_code;
  logic [15:0] highpass_corner;
  logic [7:0]  exp_q[$];
  logic [7:0]  shadow [0:11];
  logic [7:0]  wdat [0:11];
  int          n_errors, checks_done, n_restart, n_ocal, n_gcal, base, o, g;
  localparam logic [7:0] RST [0:11] = '{8'h00, 8'h52, 8'h08, 8'h32, 8'h03, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00};

  always #20 core_clk = ~core_clk;

  acfg_port uut (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .sclk(sclk),
    .din(din), .cs_n(cs_n), .dout(dout), .offset_cal_start(offset_cal_start),
    .gain_cal_start(gain_cal_start), .offset_cal_done(offset_cal_done),
    .gain_cal_done(gain_cal_done), .cal_result(cal_result),
    .conversion_restart(conversion_restart), .offset_option(offset_option),
    .sync_continuous(sync_continuous), .high_resolution(high_resolution),
    .output_rate(output_rate), .min_phase(min_phase), .filter_chain(filter_chain),
    .input_selector(input_selector), .chopping_enable(chopping_enable),
    .gain_code(gain_code), .highpass_corner(highpass_corner),
    .offset_correction(offset_correction), .gain_correction(gain_correction));
  acfg_host_model host (.sclk(sclk), .din(din), .cs_n(cs_n), .dout(dout));

  // ************************
  // Checking and closing
  // ************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expd);
    checks_done++;
    if (seen !== expd) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, expd, seen);
    end
  endtask : check
  task automatic results();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  always @(host.got) begin
    check("read byte", host.rx_last, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
  end
  always @(posedge core_clk) begin
    n_restart += conversion_restart;
    n_ocal += offset_cal_start;
    n_gcal += gain_cal_start;
  end

  // ************************
  // Command tasks
  // ************************
  task automatic wr(input logic [4:0] a, input int n);
    host.frame_begin();
    host.xfer({acfg_pkg::OP_WRITE, a});
    host.xfer({acfg_pkg::OP_COUNT, 5'(n - 1)});
    for (int i = 0; i < n; i++) begin
      host.xfer(wdat[i]);
      if (a + i == 0) shadow[0] = {6'h00, wdat[i][1:0]};
      else if (a + i == 2) shadow[2] = wdat[i] & 8'h7f;
      else if (a + i < 11) shadow[a + i] = wdat[i];
    end
    host.frame_end();
  endtask : wr
  task automatic rd(input logic [4:0] a, input int n);
    host.frame_begin();
    host.xfer(8'h11);
    host.xfer({acfg_pkg::OP_READ, a});
    host.xfer({acfg_pkg::OP_COUNT, 5'(n - 1)});
    host.listen = 1'b1;
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(a + i < 12 ? shadow[a + i] : 8'h00);
      host.xfer(8'h00);
    end
    host.listen = 1'b0;
    host.frame_end();
  endtask : rd
  task automatic fields();
    check("offset_option", offset_option, shadow[0][1:0]);
    check("sync", sync_continuous, shadow[1][7]);
    check("mode", high_resolution, shadow[1][6]);
    check("rate", output_rate, shadow[1][5:3]);
    check("phase", min_phase, shadow[1][2]);
    check("filter", filter_chain, shadow[1][1:0]);
    check("selector", input_selector, shadow[2][6:4]);
    check("amplifier_chopping_bit", chopping_enable, shadow[2][3]);
    check("gain", gain_code, shadow[2][2:0]);
    check("highpass", highpass_corner, {shadow[4], shadow[3]});
    check("offset", offset_correction, {shadow[7], shadow[6], shadow[5]});
    check("gain word", gain_correction, {shadow[10], shadow[9], shadow[8]});
  endtask : fields

  // ************************
  // Main sequence
  // ************************
  initial begin
    core_clk = 1'b0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    offset_cal_done = 1'b0;
    gain_cal_done = 1'b0;
    cal_result = 24'h000000;
    shadow = RST;
    void'($urandom(19553));
    repeat (4) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge core_clk);
    fields();
    rd(5'h00, 12);
    // Every field code, identity bits written high
    for (int k = 0; k < 8; k++) begin
      wdat[0] = {6'h3f, k[1:0]};
      wdat[1] = {k[0], k[1], k[2:0], k[2], k[1:0]};
      wdat[2] = {k[0], k[2:0], k[1], k[2:0]};
      base = n_restart;
      wr(5'h00, 3);
      check("restarts", n_restart - base, 3);
      fields();
    end
    for (int i = 0; i < 12; i++) wdat[i] = 8'($urandom);
    wr(5'h00, 12);
    rd(5'h00, 12);
    // Bad count prefix aborts the write
    base = n_restart;
    host.frame_begin();
    host.xfer(8'h41);
    host.xfer(8'h20);
    host.xfer(8'ha5);
    host.frame_end();
    check("abort restarts", n_restart - base, 0);
    fields();
    for (int j = 0; j < 2; j++) begin
      o = n_ocal;
      g = n_gcal;
      host.frame_begin();
      host.xfer(j ? acfg_pkg::OP_GAIN_CAL : acfg_pkg::OP_OFFSET_CAL);
      host.frame_end();
      check("cal start", (n_ocal - o) * 2 + (n_gcal - g), j ? 1 : 2);
      @(negedge core_clk);
      cal_result = 24'($urandom);
      offset_cal_done = (j == 0);
      gain_cal_done = (j == 1);
      for (int b = 0; b < 3; b++) shadow[5 + 3 * j + b] = cal_result[8 * b +: 8];
      @(negedge core_clk);
      offset_cal_done = 1'b0;
      gain_cal_done = 1'b0;
      @(negedge core_clk);
      fields();
    end
    // Frozen clock enable ignores a done pulse
    clk_en = 1'b0;
    offset_cal_done = 1'b1;
    cal_result = 24'($urandom);
    @(negedge core_clk);
    clk_en = 1'b1;
    offset_cal_done = 1'b0;
    @(negedge core_clk);
    fields();
    rd(5'h03, 9);
    // Second reset restores every value
    @(negedge core_clk);
    reset_n = 1'b0;
    repeat (2) @(negedge core_clk);
    reset_n = 1'b1;
    shadow = RST;
    repeat (4) @(negedge core_clk);
    fields();
    results();
  end
  initial begin
    #3000000;
    n_errors++;
    results();
  end
endmodule : adc_config_register_port_tb

// [rtl/acfg_link_if.sv]
/*
  Byte-level carrier between the serial shifter and the command logic.
  Assumes both ends run on core_clk.
*/
interface acfg_link_if;
  logic [7:0] rx_byte;
  logic       rx_valid;
  logic       cs_active;
  logic [7:0] tx_byte;
  logic       tx_load;
  logic       dout;

  modport shifter (output rx_byte, rx_valid, cs_active, dout,
                   input  tx_byte, tx_load);
  modport control (input  rx_byte, rx_valid, cs_active, dout,
                   output tx_byte, tx_load);
endinterface : acfg_link_if

// [rtl/acfg_pkg.sv]
/*
  Constants of the converter configuration register port: addresses,
  reset values, write masks, command codes and field positions.
  Assumes it is compiled before every other file of the block.
*/
// Contract
// - Read opcode: 001 plus start address
// - Read second byte: 000 plus count minus one
// - Read data driven from sixteenth falling edge
// - Write opcode: 010 plus start address
// - Write second byte: count minus one, then data
// - Any register write restarts conversion
// - Multi-register access walks consecutive addresses
// - Identity field read-only, bits 3:2 zero
// - Offset option field selects offset level
// - Main bit 7 selects sync mode
// - Main bit 6 selects power or resolution
// - Main bits 5:3 select output rate
// - Main bit 2 selects FIR phase
// - Main bits 1:0 select filter chain
// - Input selector bits 6:4, bit 7 zero
// - Input bit 3 enables amplifier chopping
// - Input bits 2:0 select power-of-two gain
// - Highpass corner word, low byte first, 0x0332
// - Offset correction word, three bytes, zero
// - Gain correction word, three bytes, 0x400000
// - Calibration completion overwrites correction words
// - Calibration opcodes are 0x60 and 0x61
package acfg_pkg;

  // ********************************
  // Register map
  // ********************************
  localparam int         REG_COUNT      = 11;
  localparam logic [4:0] ADDR_IDENT     = 5'h00;
  localparam logic [4:0] ADDR_MAIN      = 5'h01;
  localparam logic [4:0] ADDR_INPUT     = 5'h02;
  localparam logic [4:0] ADDR_CORNER_LO = 5'h03;
  localparam logic [4:0] ADDR_CORNER_HI = 5'h04;
  localparam logic [4:0] ADDR_OFS_LO    = 5'h05;
  localparam logic [4:0] ADDR_GAIN_LO   = 5'h08;
  localparam logic [4:0] ADDR_LAST      = 5'h0a;

  // Reset values, index 10 leftmost
  localparam logic [REG_COUNT-1:0][7:0] REG_RESET = {
    8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h03, 8'h32, 8'h08, 8'h52, 8'h00};

  // Writable bits
  localparam logic [7:0] WMASK_IDENT    = 8'h03;
  localparam logic [7:0] WMASK_INPUT    = 8'h7f;
  localparam logic [7:0] WMASK_FULL     = 8'hff;

  // ********************************
  // Command codes
  // ********************************
  localparam logic [2:0] OP_READ        = 3'h1;
  localparam logic [2:0] OP_WRITE       = 3'h2;
  localparam logic [2:0] OP_COUNT       = 3'h0;
  localparam logic [7:0] OP_OFFSET_CAL  = 8'h60;
  localparam logic [7:0] OP_GAIN_CAL    = 8'h61;
  localparam logic [2:0] BYTE_LAST_BIT  = 3'h7;

  // ********************************
  // Field positions
  // ********************************
  localparam int ID_LSB        = 4;
  localparam int OFS_OPT_LSB   = 0;
  localparam int SYNC_BIT      = 7;
  localparam int MODE_BIT      = 6;
  localparam int RATE_LSB      = 3;
  localparam int PHASE_BIT     = 2;
  localparam int FILTER_LSB    = 0;
  localparam int SELECT_LSB    = 4;
  localparam int AMPLIFIER_CHOPPING_BIT_BIT      = 3;
  localparam int GAIN_LSB      = 0;
  localparam int CORR_BYTES    = 3;

endpackage : acfg_pkg

// [rtl/acfg_port.sv]
/*
  Configuration register port of the converter: decodes register read,
  register write and calibration opcodes from the serial link and holds
  the eleven configuration bytes.
  Assumes the host keeps select low per command, spaces bytes by at
  least 24 master clocks and stops continuous output before reading.
*/
module acfg_port #(
  parameter logic [3:0] ID_VALUE = 4'h0  // Arbitrary identity value
) (
  // Clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  // Serial command link
  input  wire logic        sclk,
  input  wire logic        din,
  input  wire logic        cs_n,
  output logic             dout,
  // Calibration engine
  output logic             offset_cal_start,
  output logic             gain_cal_start,
  input  wire logic        offset_cal_done,
  input  wire logic        gain_cal_done,
  input  wire logic [23:0] cal_result,
  // Conversion control
  output logic             conversion_restart,
  // Configuration fields
  output logic [1:0]       offset_option,
  output logic             sync_continuous,
  output logic             high_resolution,
  output logic [2:0]       output_rate,
  output logic             min_phase,
  output logic [1:0]       filter_chain,
  output logic [2:0]       input_selector,
  output logic             chopping_enable,
  output logic [2:0]       gain_code,
  output logic [15:0]      highpass_corner,
  output logic [23:0]      offset_correction,
  output logic [23:0]      gain_correction
);

  // ********************************
  // Types
  // ********************************
  typedef enum logic [4:0] {
    ST_OPCODE   = 5'h01,
    ST_RD_COUNT = 5'h02,
    ST_WR_COUNT = 5'h04,
    ST_RD_DATA  = 5'h08,
    ST_WR_DATA  = 5'h10
  } acfg_state_type;

  typedef logic [acfg_pkg::REG_COUNT-1:0][7:0] acfg_bank_type;

  typedef struct packed {
    acfg_state_type state;
    logic [4:0]     addr;
    logic [4:0]     remain;
    acfg_bank_type  regs;
    logic [7:0]     tx_byte;
    logic           tx_load;
    logic           restart;
    logic           ofs_start;
    logic           gain_start;
  } acfg_ctrl_type;

  acfg_ctrl_type r;
  acfg_ctrl_type next_r;

  // ********************************
  // Decoding
  // ********************************
  // Read view of one address
  function automatic logic [7:0] acfg_read_reg(input acfg_bank_type regs,
                                               input logic [4:0]    addr,
                                               input logic [3:0]    id);
    logic [7:0] value;
    value = '0;
    if (addr > acfg_pkg::ADDR_LAST) begin
      value = '0;
    end else if (addr == acfg_pkg::ADDR_IDENT) begin
      value = regs[addr];
      value[7:acfg_pkg::ID_LSB] = id;
    end else begin
      value = regs[addr];
    end
    return value;
  endfunction : acfg_read_reg

  // Bits that a host write may change
  function automatic logic [7:0] acfg_write_mask(input logic [4:0] addr);
    logic [7:0] mask;
    mask = acfg_pkg::WMASK_FULL;
    if (addr == acfg_pkg::ADDR_IDENT) begin
      mask = acfg_pkg::WMASK_IDENT;
    end else if (addr == acfg_pkg::ADDR_INPUT) begin
      mask = acfg_pkg::WMASK_INPUT;
    end
    return mask;
  endfunction : acfg_write_mask

  // ********************************
  // Serial shifter
  // ********************************
  acfg_link_if link ();

  acfg_serial_shift u_shift (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .sclk     (sclk),
    .din      (din),
    .cs_n     (cs_n),
    .link     (link.shifter)
  );

  assign link.tx_byte = r.tx_byte;
  assign link.tx_load = r.tx_load;
  assign dout         = link.dout;

  // ********************************
  // Command sequencer
  // ********************************
  always_comb begin
    logic [7:0] wmask;
    logic [7:0] op;
    logic [4:0] nxt_addr;
    wmask    = acfg_write_mask(r.addr);
    op       = link.rx_byte;
    nxt_addr = r.addr + 5'h01;
    next_r   = r;
    if (clk_en) begin
      next_r.tx_load    = 1'b0;
      next_r.restart    = 1'b0;
      next_r.ofs_start  = 1'b0;
      next_r.gain_start = 1'b0;
      if (!link.cs_active) begin
        // Select high abandons any command in flight
        next_r.state   = ST_OPCODE;
        next_r.tx_byte = '0;
      end else if (link.rx_valid) begin
        unique case (r.state)
          ST_OPCODE: begin
            if (op[7:5] == acfg_pkg::OP_READ) begin
              next_r.addr  = op[4:0];
              next_r.state = ST_RD_COUNT;
            end else if (op[7:5] == acfg_pkg::OP_WRITE) begin
              next_r.addr  = op[4:0];
              next_r.state = ST_WR_COUNT;
            end else if (op == acfg_pkg::OP_OFFSET_CAL) begin
              next_r.ofs_start = 1'b1;
            end else if (op == acfg_pkg::OP_GAIN_CAL) begin
              next_r.gain_start = 1'b1;
            end
          end
          ST_RD_COUNT: begin
            if (op[7:5] == acfg_pkg::OP_COUNT) begin
              next_r.remain  = op[4:0];
              // Loaded at rise 16, driven from fall 16
              next_r.tx_byte = acfg_read_reg(r.regs, r.addr, ID_VALUE);
              next_r.tx_load = 1'b1;
              next_r.state   = ST_RD_DATA;
            end else begin
              next_r.state = ST_OPCODE;
            end
          end
          ST_WR_COUNT: begin
            if (op[7:5] == acfg_pkg::OP_COUNT) begin
              next_r.remain = op[4:0];
              next_r.state  = ST_WR_DATA;
            end else begin
              next_r.state = ST_OPCODE;
            end
          end
          ST_RD_DATA: begin
            next_r.tx_load = 1'b1;
            if (r.remain == '0) begin
              next_r.tx_byte = '0;
              next_r.state   = ST_OPCODE;
            end else begin
              next_r.addr    = nxt_addr;
              next_r.remain  = r.remain - 5'h01;
              next_r.tx_byte = acfg_read_reg(r.regs, nxt_addr, ID_VALUE);
            end
          end
          ST_WR_DATA: begin
            if (r.addr <= acfg_pkg::ADDR_LAST) begin
              // Undefined codes are stored as written
              next_r.regs[r.addr] = (r.regs[r.addr] & ~wmask) | (op & wmask);
            end
            next_r.restart = 1'b1;
            if (r.remain == '0) begin
              next_r.state = ST_OPCODE;
            end else begin
              next_r.addr   = nxt_addr;
              next_r.remain = r.remain - 5'h01;
            end
          end
        endcase
      end
      // Calibration results take precedence over a host write
      for (int i = 0; i < acfg_pkg::CORR_BYTES; i++) begin
        if (offset_cal_done) begin
          next_r.regs[int'(acfg_pkg::ADDR_OFS_LO) + i] = cal_result[8*i +: 8];
        end
        if (gain_cal_done) begin
          next_r.regs[int'(acfg_pkg::ADDR_GAIN_LO) + i] = cal_result[8*i +: 8];
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      r.state      <= ST_OPCODE;
      r.addr       <= '0;
      r.remain     <= '0;
      r.regs       <= acfg_pkg::REG_RESET;
      r.tx_byte    <= '0;
      r.tx_load    <= 1'b0;
      r.restart    <= 1'b0;
      r.ofs_start  <= 1'b0;
      r.gain_start <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  // Conversion path drops 63 results on this pulse
  assign conversion_restart = r.restart;
  assign offset_cal_start   = r.ofs_start;
  assign gain_cal_start     = r.gain_start;

  assign offset_option   = r.regs[acfg_pkg::ADDR_IDENT][acfg_pkg::OFS_OPT_LSB +: 2];
  assign sync_continuous = r.regs[acfg_pkg::ADDR_MAIN][acfg_pkg::SYNC_BIT];
  assign high_resolution = r.regs[acfg_pkg::ADDR_MAIN][acfg_pkg::MODE_BIT];
  assign output_rate     = r.regs[acfg_pkg::ADDR_MAIN][acfg_pkg::RATE_LSB +: 3];
  assign min_phase       = r.regs[acfg_pkg::ADDR_MAIN][acfg_pkg::PHASE_BIT];
  assign filter_chain    = r.regs[acfg_pkg::ADDR_MAIN][acfg_pkg::FILTER_LSB +: 2];
  assign input_selector  = r.regs[acfg_pkg::ADDR_INPUT][acfg_pkg::SELECT_LSB +: 3];
  assign chopping_enable = r.regs[acfg_pkg::ADDR_INPUT][acfg_pkg::AMPLIFIER_CHOPPING_BIT_BIT];
  assign gain_code       = r.regs[acfg_pkg::ADDR_INPUT][acfg_pkg::GAIN_LSB +: 3];

  assign highpass_corner = {r.regs[acfg_pkg::ADDR_CORNER_HI],
                            r.regs[acfg_pkg::ADDR_CORNER_LO]};

  // Three-byte words, low byte at the lowest address
  generate
    for (genvar g = 0; g < acfg_pkg::CORR_BYTES; g++) begin : g_corr
      assign offset_correction[8*g +: 8] =
        r.regs[int'(acfg_pkg::ADDR_OFS_LO) + g];
      assign gain_correction[8*g +: 8] =
        r.regs[int'(acfg_pkg::ADDR_GAIN_LO) + g];
    end
  endgenerate

endmodule : acfg_port

// [rtl/acfg_serial_shift.sv]
/*
  Serial shifter: synchronises the link pins, assembles received bytes
  on rising serial clock edges and shifts reply bytes out on falling
  edges. Assumes the serial clock is far slower than core_clk.
*/
module acfg_serial_shift (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  // Serial pins
  input  wire logic sclk,
  input  wire logic din,
  input  wire logic cs_n,
  // Byte side
  acfg_link_if.shifter link
);

  typedef struct packed {
    logic       sclk_meta;
    logic       sclk_sync;
    logic       sclk_prev;
    logic       din_meta;
    logic       din_sync;
    logic       cs_meta;
    logic       cs_sync;
    logic [2:0] bit_cnt;
    logic [7:0] rx_sh;
    logic [7:0] rx_byte;
    logic       rx_valid;
    logic [7:0] tx_buf;
    logic       tx_fresh;
    logic [7:0] tx_sh;
    logic       dout;
  } acfg_shift_type;

  acfg_shift_type r;
  acfg_shift_type next_r;
  logic           rise;
  logic           fall;

  assign rise = r.sclk_sync & ~r.sclk_prev;
  assign fall = ~r.sclk_sync & r.sclk_prev;

  always_comb begin
    next_r = r;
    if (clk_en) begin
      next_r.rx_valid  = 1'b0;
      next_r.sclk_meta = sclk;
      next_r.sclk_sync = r.sclk_meta;
      next_r.sclk_prev = r.sclk_sync;
      next_r.din_meta  = din;
      next_r.din_sync  = r.din_meta;
      next_r.cs_meta   = cs_n;
      next_r.cs_sync   = r.cs_meta;
      if (r.cs_sync) begin
        next_r.bit_cnt  = '0;
        next_r.dout     = 1'b0;
        next_r.tx_fresh = 1'b0;
        next_r.tx_sh    = '0;
      end else begin
        if (rise) begin
          next_r.rx_sh   = {r.rx_sh[6:0], r.din_sync};
          next_r.bit_cnt = r.bit_cnt + 3'h1;
          if (r.bit_cnt == acfg_pkg::BYTE_LAST_BIT) begin
            next_r.rx_byte  = {r.rx_sh[6:0], r.din_sync};
            next_r.rx_valid = 1'b1;
          end
        end
        // Freshly loaded byte goes out MSB first on the next fall
        if (fall) begin
          if (r.tx_fresh) begin
            next_r.dout     = r.tx_buf[7];
            next_r.tx_sh    = {r.tx_buf[6:0], 1'b0};
            next_r.tx_fresh = 1'b0;
          end else begin
            next_r.dout  = r.tx_sh[7];
            next_r.tx_sh = {r.tx_sh[6:0], 1'b0};
          end
        end
        // Load after the shift so a new byte is never lost
        if (link.tx_load) begin
          next_r.tx_buf   = link.tx_byte;
          next_r.tx_fresh = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      r         <= '0;
      r.cs_meta <= 1'b1;
      r.cs_sync <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign link.rx_byte   = r.rx_byte;
  assign link.rx_valid  = r.rx_valid;
  assign link.cs_active = ~r.cs_sync;
  assign link.dout      = r.dout;

endmodule : acfg_serial_shift
